/* hw/tmr_regs.svh */
// Register map, field positions, reset values and divider counts of the timer.
// Included by bare name; holds definitions only.
`ifndef TMR_REGS_SVH
`define TMR_REGS_SVH

// Byte offsets of the registers on the APB slave.
`define TM_OFS_CTRL 8'h00
`define TM_OFS_IEN 8'h04
`define TM_OFS_IDIS 8'h08
`define TM_OFS_IENA 8'h0c
`define TM_OFS_STAT 8'h10
`define TM_OFS_CH1 8'h14
`define TM_OFS_CH2 8'h18
`define TM_OFS_CNT 8'h1c
`define TM_OFS_CAP 8'h20

// Field positions.
`define TM_CH_LEVEL_BIT 8
`define TM_CH_FORCE_BIT 9
`define TM_IE_CMP 0
`define TM_IE_CAP 1
`define TM_IE_OVF 2
`define TM_FL_CMP1 0
`define TM_FL_CMP2 1
`define TM_FL_CAP 2
`define TM_FL_OVF 3

// Reset values.
`define TM_CTRL_RST 2'h1
`define TM_IEN_RST 3'h0
`define TM_PIN_RST 1'b0

// Terminal counts of the prescaler, one less than the division ratio.
`define TM_TC_DIV2 13'h0001
`define TM_TC_DIV4 13'h0003
`define TM_TC_DIV8 13'h0007
`define TM_TC_DIV8000 13'h1f3f

`endif

/* hw/tmr_pkg.sv */
// Types shared by the timer modules.
// Assumes nothing of its surroundings.
package tmr_pkg;
    // Count clock selection, in the order of the control field encoding.
    typedef enum logic [1:0] {DIV_2, DIV_4, DIV_8, DIV_8000} presc_sel_t;
    // Flag vector: two compare flags, capture, overflow.
    typedef logic [3:0] flags_t;
endpackage : tmr_pkg

/* hw/cmp_if.sv */
// Carrier between the timer core and one compare channel.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface cmp_if;
    logic count_step; // Counter moved to a new value this cycle.
    logic [7:0] count; // Current counter value.
    logic [7:0] value; // Programmed compare value.
    logic level; // Level driven on a compare event, 1 = high.
    logic force_pulse; // One-cycle forced compare request.
    logic match; // One-cycle compare match.
    logic pin; // Registered output pin level.
    modport chan(input count_step, count, value, level, force_pulse, output match, pin);
    modport core(output count_step, count, value, level, force_pulse, input match, pin);
endinterface : cmp_if
`default_nettype wire

/* hw/cmp_channel.sv */
// One output compare channel: match detection and the pin it drives.
// Assumes the core gives a one-cycle step with each new counter value.
`timescale 1ns/1ns
`default_nettype none
`include "tmr_regs.svh"
module cmp_channel
    import tmr_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    cmp_if.chan ch
);
    logic pin; // Current pin level.
    logic next_pin; // Pin level for the next cycle.
    logic hit; // Counter equals the compare value on a fresh count.

    // A match counts once per counter value.
    assign hit = ch.count_step && (ch.count == ch.value);
    assign ch.match = hit;
    assign ch.pin = pin;

    // Next pin level: a match or a forced compare drives the chosen level.
    always_comb begin
        next_pin = pin;
        if (hit || ch.force_pulse) begin
            next_pin = ch.level;
        end
    end

    // Pin register.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin <= `TM_PIN_RST;
        end else begin
            pin <= next_pin;
        end
    end

    // A match drives the selected level.
    chk_match_level: assert property (@(posedge clk) disable iff (!nrst)
        hit |=> pin == $past(ch.level)) else $error("pin wrong after match");
    // A forced compare drives the selected level, whatever the value.
    chk_force_level: assert property (@(posedge clk) disable iff (!nrst)
        ch.force_pulse |=> pin == $past(ch.level)) else $error("pin wrong after force");
endmodule : cmp_channel
`default_nettype wire

/* hw/tmr_oc_top.sv */
// 8-bit timer with two output compare channels, capture, overflow and masking.
// Assumes an APB master on CLK and an asynchronous capture pin; the compare pins are registered on CLK.
//
// How it works
// - One write masks any set of sources.
// - Masked compare source raises no request.
// - Masked capture source raises no request.
// - Masked overflow source raises no request.
// - Masking leaves the flags still being set.
// - Two independent compare channels, separately configured.
// - Forced compare drives the level at once.
// - Low level selected drives pin low.
// - High level selected drives pin high.
// - Every compare match sets its flag; a forced compare sets none.
// - Forced compare ignores the compare value.
// - Sources enable individually or together.
// - Count clock CPU by 2/4/8/8000, 4 at reset.
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "tmr_regs.svh"
module tmr_oc_top
    import tmr_pkg::*;
(
    input wire logic CLK,
    input wire logic NRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic CAPTURE_PIN,
    output logic COMPARE_CHANNEL_ONE,
    output logic COMPARE_CHANNEL_TWO,
    output logic TIMER_IRQ
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations.

    presc_sel_t presc_sel; // Count clock selection.
    presc_sel_t next_presc_sel;
    logic [2:0] irq_en; // Source enables: compare, capture, overflow.
    logic [2:0] next_irq_en;
    flags_t flags; // Sticky event flags.
    flags_t next_flags;
    flags_t events; // Events seen this cycle.
    logic [7:0] cmp_value [2]; // Compare value of each channel.
    logic [7:0] next_cmp_value [2];
    logic cmp_level [2]; // Selected level of each channel.
    logic next_cmp_level [2];
    logic force_req [2]; // Forced compare pulse to each channel.
    logic next_force_req [2];
    logic [12:0] presc; // Prescaler count.
    logic [12:0] next_presc;
    logic [12:0] presc_tc; // Terminal count for the selected ratio.
    logic tick; // One-cycle count clock.
    logic [7:0] count; // Free-running counter.
    logic [7:0] next_count;
    logic count_step; // Counter holds a fresh value.
    logic overflow; // Counter wraps this cycle.
    logic [2:0] cap_sync; // Capture pin synchroniser.
    logic cap_level; // Filtered capture pin level.
    logic next_cap_level;
    logic cap_event; // Rising edge of the filtered level.
    logic [7:0] cap_value; // Counter value at the last capture.
    logic [7:0] next_cap_value;
    logic [31:0] rdata; // Read data held for the access phase.
    logic [31:0] next_rdata;
    logic irq; // Registered request.
    logic next_irq;
    logic wr_access; // Write takes effect this edge.
    logic setup_rd; // Read setup cycle.
    flags_t enabled_flags; // Flags whose source is enabled, seen by the request check.

    cmp_if chan_bus [2] (); // Links to the two compare channels.

    ////////////////////////////////////////////////////////////////////////////
    // Helpers.

    // True when an address names a mapped register.
    function automatic logic addr_mapped(input logic [7:0] a);
        unique case (a)
            `TM_OFS_CTRL, `TM_OFS_IEN, `TM_OFS_IDIS, `TM_OFS_IENA, `TM_OFS_STAT,
            `TM_OFS_CH1, `TM_OFS_CH2, `TM_OFS_CNT, `TM_OFS_CAP: addr_mapped = 1'b1;
            default: addr_mapped = 1'b0;
        endcase
    endfunction : addr_mapped

    // True when a write access targets the given register.
    function automatic logic wr_hit(input logic [7:0] ofs);
        wr_hit = wr_access && (PADDR == ofs);
    endfunction : wr_hit

    ////////////////////////////////////////////////////////////////////////////
    // APB handshake: zero wait states, error on unmapped addresses.

    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !addr_mapped(PADDR);
    assign wr_access = PSEL && PENABLE && PWRITE && addr_mapped(PADDR);
    assign setup_rd = PSEL && !PENABLE && !PWRITE;
    assign PRDATA = rdata;

    // Read data is captured in the setup cycle and stands through the access.
    always_comb begin
        next_rdata = rdata;
        if (setup_rd) begin
            unique case (PADDR)
                `TM_OFS_CTRL: next_rdata = {30'h0, presc_sel};
                `TM_OFS_IEN: next_rdata = {29'h0, irq_en};
                `TM_OFS_STAT: next_rdata = {28'h0, flags};
                `TM_OFS_CH1: next_rdata = {23'h0, cmp_level[0], cmp_value[0]};
                `TM_OFS_CH2: next_rdata = {23'h0, cmp_level[1], cmp_value[1]};
                `TM_OFS_CNT: next_rdata = {24'h0, count};
                `TM_OFS_CAP: next_rdata = {24'h0, cap_value};
                default: next_rdata = 32'h0;
            endcase
        end
    end

    // Read data register.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rdata <= 32'h0;
        end else begin
            rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers.

    // Control, enables and channel set-up follow software writes.
    always_comb begin
        next_presc_sel = presc_sel;
        next_irq_en = irq_en;
        if (wr_hit(`TM_OFS_CTRL)) begin
            next_presc_sel = presc_sel_t'(PWDATA[1:0]);
        end
        if (wr_hit(`TM_OFS_IEN)) begin
            next_irq_en = PWDATA[2:0];
        end
        if (wr_hit(`TM_OFS_IDIS)) begin
            next_irq_en = irq_en & ~PWDATA[2:0];
        end
        if (wr_hit(`TM_OFS_IENA)) begin
            next_irq_en = irq_en | PWDATA[2:0];
        end
        for (int i = 0; i < 2; i++) begin
            next_cmp_value[i] = cmp_value[i];
            next_cmp_level[i] = cmp_level[i];
            next_force_req[i] = 1'b0;
            if (wr_hit(i == 0 ? `TM_OFS_CH1 : `TM_OFS_CH2)) begin
                next_cmp_value[i] = PWDATA[7:0];
                next_cmp_level[i] = PWDATA[`TM_CH_LEVEL_BIT];
                next_force_req[i] = PWDATA[`TM_CH_FORCE_BIT];
            end
        end
    end

    // Configuration register bank.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            presc_sel <= presc_sel_t'(`TM_CTRL_RST);
            irq_en <= `TM_IEN_RST;
            for (int i = 0; i < 2; i++) begin
                cmp_value[i] <= 8'h00;
                cmp_level[i] <= 1'b0;
                force_req[i] <= 1'b0;
            end
        end else begin
            presc_sel <= next_presc_sel;
            irq_en <= next_irq_en;
            for (int i = 0; i < 2; i++) begin
                cmp_value[i] <= next_cmp_value[i];
                cmp_level[i] <= next_cmp_level[i];
                force_req[i] <= next_force_req[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Prescaler and free-running counter.

    // Terminal count of the selected division ratio.
    always_comb begin
        unique case (presc_sel)
            DIV_2: presc_tc = `TM_TC_DIV2;
            DIV_4: presc_tc = `TM_TC_DIV4;
            DIV_8: presc_tc = `TM_TC_DIV8;
            DIV_8000: presc_tc = `TM_TC_DIV8000;
        endcase
    end

    // A ratio change may shorten the period once; the count then wraps at once.
    assign tick = (presc >= presc_tc);
    assign overflow = tick && (count == 8'hff);

    // Next prescaler and counter values.
    always_comb begin
        next_presc = tick ? 13'h0000 : presc + 13'h0001;
        next_count = tick ? count + 8'h01 : count;
    end

    // Prescaler, counter and the step marker that follows each tick.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            presc <= 13'h0000;
            count <= 8'h00;
            count_step <= 1'b0;
        end else begin
            presc <= next_presc;
            count <= next_count;
            count_step <= tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Capture input: three flops, a change counts once the last two agree.

    assign next_cap_level = (cap_sync[1] == cap_sync[2]) ? cap_sync[2] : cap_level;
    assign cap_event = next_cap_level && !cap_level;
    assign next_cap_value = cap_event ? count : cap_value;

    // Synchroniser, filtered level and captured value.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            cap_sync <= 3'h0;
            cap_level <= 1'b0;
            cap_value <= 8'h00;
        end else begin
            cap_sync <= {cap_sync[1:0], CAPTURE_PIN};
            cap_level <= next_cap_level;
            cap_value <= next_cap_value;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Compare channels.

    for (genvar g = 0; g < 2; g++) begin : g_chan
        assign chan_bus[g].count_step = count_step;
        assign chan_bus[g].count = count;
        assign chan_bus[g].value = cmp_value[g];
        assign chan_bus[g].level = cmp_level[g];
        assign chan_bus[g].force_pulse = force_req[g];
        assign events[g] = chan_bus[g].match;
        // Each channel runs on its own value and level.
        cmp_channel u_chan (
            .clk(CLK),
            .nrst(NRST),
            .ch(chan_bus[g])
        );
    end

    assign COMPARE_CHANNEL_ONE = chan_bus[0].pin;
    assign COMPARE_CHANNEL_TWO = chan_bus[1].pin;
    assign events[`TM_FL_CAP] = cap_event;
    assign events[`TM_FL_OVF] = overflow;

    ////////////////////////////////////////////////////////////////////////////
    // Flags and the shared request.

    // Flags set on events regardless of enables; write one to clear, set wins.
    always_comb begin
        next_flags = flags;
        if (wr_hit(`TM_OFS_STAT)) begin
            next_flags = flags & ~PWDATA[3:0];
        end
        next_flags = next_flags | events;
        next_irq = ((flags[`TM_FL_CMP1] || flags[`TM_FL_CMP2]) && irq_en[`TM_IE_CMP])
            || (flags[`TM_FL_CAP] && irq_en[`TM_IE_CAP])
            || (flags[`TM_FL_OVF] && irq_en[`TM_IE_OVF]);
    end

    // Flag and request registers.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            flags <= 4'h0;
            irq <= 1'b0;
        end else begin
            flags <= next_flags;
            irq <= next_irq;
        end
    end

    assign TIMER_IRQ = irq;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    // Each flag paired with the enable of its source, compare enable used twice.
    assign enabled_flags = flags & {irq_en[`TM_IE_OVF], irq_en[`TM_IE_CAP],
        irq_en[`TM_IE_CMP], irq_en[`TM_IE_CMP]};

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    chk_mask_write: assert property (wr_hit(`TM_OFS_IDIS) |=>
        irq_en == ($past(irq_en) & ~$past(PWDATA[2:0])))
        else $error("disable write did not mask the chosen sources");
    chk_cmp_masked: assert property (!irq_en[`TM_IE_CMP] && !irq_en[`TM_IE_CAP]
        && !irq_en[`TM_IE_OVF] |=> !TIMER_IRQ)
        else $error("request raised with every source masked");
    chk_cap_masked: assert property (!irq_en[`TM_IE_CAP] && !irq_en[`TM_IE_CMP]
        && !flags[`TM_FL_OVF] |=> !TIMER_IRQ)
        else $error("capture raised a masked request");
    chk_ovf_masked: assert property (!irq_en[`TM_IE_OVF] && !irq_en[`TM_IE_CMP]
        && !irq_en[`TM_IE_CAP] && overflow |=> !TIMER_IRQ)
        else $error("overflow raised a masked request");
    chk_flag_kept: assert property (overflow && !irq_en[`TM_IE_OVF] |=> flags[`TM_FL_OVF])
        else $error("masked overflow did not set its flag");
    chk_match_flag: assert property (chan_bus[1].match |=> flags[`TM_FL_CMP2])
        else $error("compare match did not set its flag");
    chk_match_cause: assert property (count_step && count == cmp_value[0] |->
        chan_bus[0].match) else $error("counter equal to value gave no match");
    // A ratio written just after the tick legally stretches the second period.
    chk_div_two: assert property (tick && presc_sel == DIV_2
        |=> !tick ##1 (tick || presc_sel != DIV_2))
        else $error("divide by two spacing wrong");
    chk_irq_cause: assert property (TIMER_IRQ |-> $past(enabled_flags) != 4'h0)
        else $error("request without an enabled flag");
    // Channel one sets its own flag on every match.
    chk_match_one: assert property (chan_bus[0].match |=> flags[`TM_FL_CMP1])
        else $error("compare match on channel one did not set its flag");
    // A capture sets its flag whatever the enables say.
    chk_cap_flag: assert property (cap_event |=> flags[`TM_FL_CAP])
        else $error("capture did not set its flag");
    // An enable-set write adds exactly the chosen sources.
    chk_enable_write: assert property (wr_hit(`TM_OFS_IENA) |=>
        irq_en == ($past(irq_en) | $past(PWDATA[2:0])))
        else $error("enable write did not add the chosen sources");
    // A forced compare moves the pin only; without a match no flag appears.
    chk_force_noflag: assert property (force_req[0] && !chan_bus[0].match
        && !flags[`TM_FL_CMP1] |=> !flags[`TM_FL_CMP1])
        else $error("forced compare set a compare flag");
    chk_set_wins: assert property (overflow && wr_hit(`TM_OFS_STAT) |=> flags[`TM_FL_OVF])
        else $error("overflow lost against a clear");
    chk_cmp_irq: assert property (irq_en[`TM_IE_CMP] && flags[`TM_FL_CMP1] |=> TIMER_IRQ)
        else $error("enabled compare flag gave no request");

endmodule : tmr_oc_top
`default_nettype wire

/* sim/tmr_oc_top_tb.sv */
// Self-checking bench of the timer: count clock, compare pins, flags and masking.
// Assumes the timer top, its register header and a zero-wait APB slave on CLK.
`timescale 1ns/1ns
`default_nettype none
`include "tmr_regs.svh"
// Compares one value against its expectation and counts the comparison.
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin err_total++; \
    $display("mismatch %s expected %0h seen %0h", nm, ex, gt); end end
module tmr_oc_top_tb
    import tmr_pkg::*;
;
    logic clk, nrst, psel, penable, pwrite, cap_pin; // Bench-driven inputs.
    logic [7:0] paddr; // Byte address of the transfer.
    logic [31:0] pwdata, prdata; // Write data and read data.
    logic pready, pslverr, err_last; // Answer of the slave and its captured error.
    logic pin_one, pin_two, irq; // Compare pins and shared request.
    int err_total = 0, cmp_count = 0, cyc = 0; // Mismatches, comparisons, elapsed cycles.
    int div[4] = '{2, 4, 8, 8000}; // Division ratio per clock selection.

    tmr_oc_top DUT (.CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .CAPTURE_PIN(cap_pin),
        .COMPARE_CHANNEL_ONE(pin_one), .COMPARE_CHANNEL_TWO(pin_two), .TIMER_IRQ(irq));

    ////////////////////////////////////////////////////////////////////////////////
    // Free-running 50 ns clock.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Cuts a hang short; the whole run needs well under this many cycles.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Prints the verdict and ends the run.
    task automatic wrap_up();
        if (err_total == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up

    // One APB transfer: setup, then access held until ready is seen at an edge.
    task automatic apb(input logic wr, input logic [7:0] adr, input logic [31:0] dat,
                       output logic [31:0] q);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= adr;
        pwdata <= dat;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        // The answer is taken at the edge that sees ready, before the release.
        q = prdata;
        err_last = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Register write without interest in the answer.
    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] dummy;
        apb(1'b1, adr, dat, dummy);
    endtask : wr

    // Register read.
    task automatic rd(input logic [7:0] adr, output logic [31:0] q);
        apb(1'b0, adr, 32'h0, q);
    endtask : rd

    // Waits, bounded, for a compare pin to reach a level.
    task automatic wait_pin(input int sel, input logic lvl, output logic seen);
        int n;
        n = 0;
        seen = (sel == 1) ? pin_one : pin_two;
        while (seen !== lvl && n < 2000) begin
            @(negedge clk);
            n++;
            seen = (sel == 1) ? pin_one : pin_two;
        end
    endtask : wait_pin

    // True when a value lies inside an inclusive range.
    function automatic logic in_rng(input logic [31:0] v, input int lo, input int hi);
        return (v >= lo) && (v <= hi);
    endfunction : in_rng

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        logic [31:0] q, a, b;
        logic s;
        int d, ex;
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        cap_pin = 1'b0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        // Reset state and an unmapped place.
        rd(`TM_OFS_CTRL, q); `CHK("ctrl reset", 32'h1, q)
        rd(`TM_OFS_IEN, q); `CHK("enable reset", 32'h0, q)
        `CHK("irq reset", 1'b0, irq)
        apb(1'b0, 8'h40, 32'h0, q); `CHK("unmapped error", 1'b1, err_last)
        `CHK("ready high", 1'b1, pready)
        `CHK("unmapped data", 32'h0, q)
        // Count rate over 80 cycles for every clock selection.
        for (int i = 0; i < 4; i++) begin
            wr(`TM_OFS_CTRL, i);
            rd(`TM_OFS_CNT, a);
            repeat (77) @(posedge clk);
            rd(`TM_OFS_CNT, b);
            d = int'((b - a) & 32'hff);
            ex = 80 / div[i];
            `CHK("count rate", 1'b1, (d + 1 >= ex) && (d <= ex + 1))
        end
        wr(`TM_OFS_CTRL, 32'h0);
        // Forced compare on channel two drives high at once.
        wr(`TM_OFS_CH2, 32'h300);
        repeat (3) @(negedge clk);
        `CHK("force two", 1'b1, pin_two)
        // Channel one high at 0x10, channel two low at 0x20.
        wr(`TM_OFS_CH1, 32'h110);
        rd(`TM_OFS_CH1, q); `CHK("ch1 readback", 32'h110, q)
        wait_pin(1, 1'b1, s); `CHK("pin one high", 1'b1, s)
        rd(`TM_OFS_CNT, q); `CHK("match one", 1'b1, in_rng(q, 8'h10, 8'h13))
        // Re-arm channel two high, then let its own match pull it low.
        wr(`TM_OFS_CH2, 32'h320);
        wr(`TM_OFS_CH2, 32'h020);
        wr(`TM_OFS_STAT, 32'hf);
        `CHK("two still high", 1'b1, pin_two)
        wait_pin(2, 1'b0, s); `CHK("pin two low", 1'b0, s)
        rd(`TM_OFS_CNT, q); `CHK("match two", 1'b1, in_rng(q, 8'h20, 8'h23))
        rd(`TM_OFS_STAT, q); `CHK("cmp flags", 2'h2, q[1:0])
        `CHK("cmp masked", 1'b0, irq)
        // Forced compare ignores the compare value, at 0xfc and at 0x00.
        wr(`TM_OFS_CH1, 32'h2fc);
        repeat (3) @(negedge clk);
        `CHK("force low", 1'b0, pin_one)
        wr(`TM_OFS_CH1, 32'h300);
        repeat (3) @(negedge clk);
        `CHK("force high", 1'b1, pin_one)
        // All sources masked: flags still set by capture, overflow and matches.
        wr(`TM_OFS_STAT, 32'hf);
        cap_pin <= 1'b1;
        q = 32'h0;
        // Channel two matches only 32 counts after the wrap, so wait for all four.
        for (int n = 0; n < 300 && q[3:0] !== 4'hf; n++) rd(`TM_OFS_STAT, q);
        rd(`TM_OFS_STAT, q); `CHK("masked flags", 32'hf, q)
        `CHK("all masked", 1'b0, irq)
        // Near-frozen count; each source enabled and masked on its own.
        wr(`TM_OFS_CTRL, 32'h3);
        for (int i = 0; i < 3; i++) begin
            wr(`TM_OFS_IEN, 32'h1 << i);
            repeat (2) @(negedge clk);
            `CHK("single enable", 1'b1, irq)
            wr(`TM_OFS_IDIS, 32'h1 << i);
            repeat (2) @(negedge clk);
            `CHK("single mask", 1'b0, irq)
        end
        // Enable all together, then mask two in one write.
        wr(`TM_OFS_STAT, 32'h3);
        wr(`TM_OFS_IENA, 32'h7);
        repeat (2) @(negedge clk);
        `CHK("all enabled", 1'b1, irq)
        rd(`TM_OFS_IEN, q); `CHK("enable bits", 32'h7, q)
        wr(`TM_OFS_IDIS, 32'h6);
        repeat (2) @(negedge clk);
        `CHK("two masked", 1'b0, irq)
        rd(`TM_OFS_IEN, q); `CHK("one left", 32'h1, q)
        rd(`TM_OFS_STAT, q); `CHK("flags kept", 2'h3, q[3:2])
        wrap_up();
    end
endmodule : tmr_oc_top_tb
`undef CHK
`default_nettype wire
